/* File: pue_pkg.sv */
// Package with offsets, field positions, reset values and event indices
package pue_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_EN = 8'h08;
    localparam logic [7:0] OFS_CHAN_CTRL = 8'h0c;
    localparam logic [7:0] OFS_DESC_PTR = 8'h10;
    // Control fields
    localparam int CTL_PARITY_RESPONSE_ENABLE = 0;
    localparam int CTL_IN_DATA_BE = 1;
    localparam int CTL_OUT_DATA_BE = 2;
    localparam int CTL_IN_BEN_SWAP = 3;
    localparam int CTL_OUT_BEN_SWAP = 4;
    localparam int CTL_W = 5;
    localparam logic [4:0] CTL_RESET = 5'h00;
    // Status flag positions
    localparam int F_TGT_ADR = 0;
    localparam int F_DTX = 1;
    localparam int F_CSR_BE = 2;
    localparam int F_TGT_WPAR = 3;
    localparam int F_TGT_SRAM = 4;
    localparam int F_TGT_DRAM = 5;
    localparam int F_DMA_DRAM = 6;
    localparam int F_DMA_SRAM = 7;
    localparam int F_DPE = 8;
    localparam int F_DATA_PARITY_DETECTED_FLAG = 9;
    localparam int F_RMA = 10;
    localparam int F_RTA = 11;
    localparam int F_RECEIVED_SYSTEM_ERROR_FLAG = 12;
    localparam int NFLAG = 13;
    localparam int ST_DET_PAR = 16;
    localparam logic [12:0] FLAG_RESET = 13'h0000;
    // Channel control fields
    localparam int CH_ENABLE = 0;
    localparam int CH_ERROR = 1;
    // PCI-side event vector bit positions
    localparam int EV_TDEC = 0;
    localparam int EV_APAR = 1;
    localparam int EV_TWR = 2;
    localparam int EV_TRD = 3;
    localparam int EV_DPAR = 4;
    localparam int EV_CSR = 5;
    localparam int EV_CSR_LOCAL = 6;
    localparam int EV_DTX = 7;
    localparam int EV_MWR = 8;
    localparam int EV_MRD = 9;
    localparam int EV_MDMA = 10;
    localparam int EV_MABT = 11;
    localparam int EV_TABT = 12;
    localparam int EV_DETECTED_PARITY_STATUS_N = 13;
    localparam int EV_SERR_N = 14;
    localparam int EV_PRST_N = 15;
    localparam int EV_CBE_LO = 16;
    localparam int EVT_W = 20;
    // Idle event vector: active-low pins released
    localparam logic [19:0] EVT_IDLE = 20'h0e000;
endpackage

/* File: pue_error_lane.sv */
// PCI unit error response, DMA channel error handling and byte lane alignment
`timescale 1ns/1ps
module pue_error_lane #(
    parameter int DESC_W = 32,
    parameter int WC_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite register slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // PCI side, sampled through pciClk edges
    input wire logic pciClk,
    input wire logic [19:0] pciEvt,
    output logic tgtClaim,
    output logic tgtAbort,
    output logic tgtDropWrite,
    output logic delayedReadValid,
    output logic perrOut,
    output logic perrOeN,
    output logic mstStop,
    // Internal memory and DMA events
    input wire logic tgtSramErr,
    input wire logic tgtDramErr,
    input wire logic dmaDramErr,
    input wire logic dmaSramErr,
    input wire logic delayedReadStart,
    input wire logic descLoad,
    input wire logic [WC_W-1:0] descWordCount,
    output logic descRetire,
    output logic chanReset,
    // Direct transfers from the core or engines
    input wire logic dirReq,
    input wire logic dirWrite,
    input wire logic coreRdValid,
    input wire logic [31:0] coreRdData,
    input wire logic coreRdParErr,
    output logic dirIssue,
    output logic dirRspValid,
    output logic [31:0] dirRspData,
    output logic dirRspErr,
    // Lane alignment and core interrupt
    input wire logic [63:0] pciDataIn,
    input wire logic [7:0] pciBenIn,
    input wire logic [63:0] memDataIn,
    input wire logic [7:0] memBenIn,
    output logic [63:0] memDataOut,
    output logic [7:0] memBenOut,
    output logic [63:0] pciDataOut,
    output logic [7:0] pciBenOut,
    output logic coreIrq
);

    function automatic logic [63:0] swapBytes(input logic [63:0] d);
        logic [63:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[(i ^ 3) * 8 +: 8] = d[i * 8 +: 8];
        end
        return r;
    endfunction

    function automatic logic [7:0] swapBens(input logic [7:0] b);
        return {b[4], b[5], b[6], b[7], b[0], b[1], b[2], b[3]};
    endfunction

    function automatic logic beLegal(input logic [3:0] be, input logic isLocal);
        logic ok;
        ok = (be == 4'h0) || (be == 4'hf);
        if (!isLocal) begin
            ok = ok || (be == 4'he) || (be == 4'hd) || (be == 4'hb) || (be == 4'h7)
                 || (be == 4'hc) || (be == 4'h3);
        end
        return ok;
    endfunction

    // Link clock and event synchronisers
    logic pciClkS1_ff, pciClkS2_ff, pciClkS3_ff;
    logic [pue_pkg::EVT_W-1:0] evtS1_ff, evtS2_ff, evt_ff;
    logic evtValid_ff;
    logic pciEdge;

    always_ff @(posedge clk) begin
        if (rst) begin
            pciClkS1_ff <= 1'b0;
            pciClkS2_ff <= 1'b0;
            pciClkS3_ff <= 1'b0;
            evtS1_ff <= pue_pkg::EVT_IDLE;
            evtS2_ff <= pue_pkg::EVT_IDLE;
        end else begin
            pciClkS1_ff <= pciClk;
            pciClkS2_ff <= pciClkS1_ff;
            pciClkS3_ff <= pciClkS2_ff;
            evtS1_ff <= pciEvt;
            evtS2_ff <= evtS1_ff;
        end
    end

    assign pciEdge = pciClkS2_ff & ~pciClkS3_ff;

    // One sample per PCI clock; events stand for a whole link period
    always_ff @(posedge clk) begin
        if (rst) begin
            evt_ff <= pue_pkg::EVT_IDLE;
            evtValid_ff <= 1'b0;
        end else begin
            evtValid_ff <= pciEdge;
            if (pciEdge) begin
                evt_ff <= evtS2_ff;
            end
        end
    end

    // Registers
    logic [pue_pkg::CTL_W-1:0] ctrl_ff;
    logic [pue_pkg::NFLAG-1:0] flags_ff, irqEn_ff, setFlags, nxt_flags;
    logic detPar_ff, chanEnable_ff, chanError_ff;
    logic [DESC_W-1:0] descPtr_ff;
    logic perrResp;

    assign perrResp = ctrl_ff[pue_pkg::CTL_PARITY_RESPONSE_ENABLE];

    // Event decode; the PCI terms are gated by a fresh PCI sample, tMemErr, the internal part of dmaErr and pciInReset are not
    logic ev, tDec, aParBlock, csrBad, twPar, mPerrRx, mRdPar, mAbt, tAbtRx, serrRx;
    logic isDma, dmaErr, tMemErr, pciInReset;
    assign ev = evtValid_ff;
    assign tDec = ev & evt_ff[pue_pkg::EV_TDEC];
    assign aParBlock = tDec & perrResp & evt_ff[pue_pkg::EV_APAR];
    assign csrBad = tDec & ~aParBlock & evt_ff[pue_pkg::EV_CSR]
        & ~beLegal(evt_ff[pue_pkg::EV_CBE_LO +: 4], evt_ff[pue_pkg::EV_CSR_LOCAL]);
    assign twPar = tDec & ~aParBlock & perrResp & evt_ff[pue_pkg::EV_TWR]
        & evt_ff[pue_pkg::EV_DPAR];
    // DETECTED_PARITY_STATUS# against our own target read data is left to the initiator
    assign mPerrRx = ev & perrResp & evt_ff[pue_pkg::EV_MWR]
        & ~evt_ff[pue_pkg::EV_DETECTED_PARITY_STATUS_N];
    assign mRdPar = ev & perrResp & evt_ff[pue_pkg::EV_MRD] & evt_ff[pue_pkg::EV_DPAR];
    assign mAbt = ev & evt_ff[pue_pkg::EV_MABT];
    assign tAbtRx = ev & evt_ff[pue_pkg::EV_TABT];
    assign serrRx = ev & ~evt_ff[pue_pkg::EV_SERR_N]
        & (evt_ff[pue_pkg::EV_MWR] | evt_ff[pue_pkg::EV_MRD]);
    assign isDma = evt_ff[pue_pkg::EV_MDMA];
    assign tMemErr = tgtSramErr | tgtDramErr;
    assign dmaErr = dmaDramErr | dmaSramErr
        | (isDma & (mPerrRx | mRdPar | mAbt | tAbtRx));
    assign pciInReset = ~evt_ff[pue_pkg::EV_PRST_N];

    always_comb begin
        setFlags = '0;
        setFlags[pue_pkg::F_TGT_ADR] = aParBlock;
        setFlags[pue_pkg::F_DTX] = ev & evt_ff[pue_pkg::EV_DTX];
        setFlags[pue_pkg::F_CSR_BE] = csrBad;
        setFlags[pue_pkg::F_TGT_WPAR] = twPar;
        setFlags[pue_pkg::F_TGT_SRAM] = tgtSramErr;
        setFlags[pue_pkg::F_TGT_DRAM] = tgtDramErr;
        setFlags[pue_pkg::F_DMA_DRAM] = dmaDramErr;
        setFlags[pue_pkg::F_DMA_SRAM] = dmaSramErr;
        setFlags[pue_pkg::F_DPE] = mPerrRx;
        setFlags[pue_pkg::F_DATA_PARITY_DETECTED_FLAG] = mRdPar;
        setFlags[pue_pkg::F_RMA] = mAbt;
        setFlags[pue_pkg::F_RTA] = tAbtRx;
        setFlags[pue_pkg::F_RECEIVED_SYSTEM_ERROR_FLAG] = serrRx;
    end

    // AHB-Lite slave: zero wait states, always OKAY
    logic wrPend_ff;
    logic [7:0] wrAddr_ff;
    logic [31:0] hrdata_ff;
    logic addrPhase;
    logic [31:0] rdMux;
    logic statusWr, ctrlWr, irqWr, chanWr, descWr;

    assign addrPhase = hsel & hready & htrans[1];
    assign statusWr = wrPend_ff && (wrAddr_ff == pue_pkg::OFS_STATUS);
    assign ctrlWr = wrPend_ff && (wrAddr_ff == pue_pkg::OFS_CONTROL);
    assign irqWr = wrPend_ff && (wrAddr_ff == pue_pkg::OFS_IRQ_EN);
    assign chanWr = wrPend_ff && (wrAddr_ff == pue_pkg::OFS_CHAN_CTRL);
    assign descWr = wrPend_ff && (wrAddr_ff == pue_pkg::OFS_DESC_PTR);

    always_comb begin
        rdMux = 32'h0;
        case (haddr[7:0])
            pue_pkg::OFS_CONTROL: rdMux[pue_pkg::CTL_W-1:0] = ctrl_ff;
            pue_pkg::OFS_STATUS: begin
                rdMux[pue_pkg::NFLAG-1:0] = flags_ff;
                rdMux[pue_pkg::ST_DET_PAR] = detPar_ff;
            end
            pue_pkg::OFS_IRQ_EN: rdMux[pue_pkg::NFLAG-1:0] = irqEn_ff;
            pue_pkg::OFS_CHAN_CTRL: rdMux[1:0] = {chanError_ff, chanEnable_ff};
            pue_pkg::OFS_DESC_PTR: rdMux[DESC_W-1:0] = descPtr_ff;
            default: rdMux = 32'h0;
        endcase
        if (haddr[31:8] != 24'h0) begin
            rdMux = 32'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
            hrdata_ff <= 32'h0;
        end else begin
            wrPend_ff <= addrPhase & hwrite & (haddr[31:8] == 24'h0);
            if (addrPhase) begin
                wrAddr_ff <= haddr[7:0];
                hrdata_ff <= hwrite ? 32'h0 : rdMux;
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff <= pue_pkg::CTL_RESET;
            irqEn_ff <= pue_pkg::FLAG_RESET;
            descPtr_ff <= '0;
        end else begin
            if (ctrlWr) begin
                ctrl_ff <= hwdata[pue_pkg::CTL_W-1:0];
            end
            if (irqWr) begin
                irqEn_ff <= hwdata[pue_pkg::NFLAG-1:0];
            end
            // The pointer is software-only so a failed descriptor stays visible
            if (descWr) begin
                descPtr_ff <= hwdata[DESC_W-1:0];
            end
        end
    end

    // Sticky flags, write one to clear; a same-cycle event wins
    always_comb begin
        nxt_flags = flags_ff;
        if (statusWr) begin
            nxt_flags = nxt_flags & ~hwdata[pue_pkg::NFLAG-1:0];
        end
        nxt_flags = nxt_flags | setFlags;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_ff <= pue_pkg::FLAG_RESET;
            detPar_ff <= 1'b0;
        end else begin
            flags_ff <= nxt_flags;
            if (twPar | mPerrRx | mRdPar) begin
                detPar_ff <= 1'b1;
            end else if (statusWr & hwdata[pue_pkg::ST_DET_PAR]) begin
                detPar_ff <= 1'b0;
            end
        end
    end

    assign coreIrq = |(flags_ff & irqEn_ff);

    // DMA channel: an error beats a software enable in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            chanEnable_ff <= 1'b0;
            chanError_ff <= 1'b0;
            chanReset <= 1'b0;
        end else begin
            chanReset <= dmaErr;
            if (dmaErr) begin
                chanEnable_ff <= 1'b0;
            end else if (chanWr) begin
                chanEnable_ff <= hwdata[pue_pkg::CH_ENABLE];
            end
            if (dmaErr) begin
                chanError_ff <= 1'b1;
            end else if (chanWr & hwdata[pue_pkg::CH_ERROR]) begin
                chanError_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            descRetire <= 1'b0;
        end else begin
            descRetire <= descLoad && (descWordCount == '0);
        end
    end

    // Target and master responses on the PCI side
    always_ff @(posedge clk) begin
        if (rst) begin
            tgtClaim <= 1'b0;
            tgtAbort <= 1'b0;
            tgtDropWrite <= 1'b0;
            perrOeN <= 1'b1;
            mstStop <= 1'b0;
        end else begin
            if (ev) begin
                tgtClaim <= tDec & ~aParBlock;
                perrOeN <= ~(twPar | mRdPar);
            end
            tgtAbort <= tMemErr | (csrBad & evt_ff[pue_pkg::EV_TRD]);
            tgtDropWrite <= twPar | (csrBad & evt_ff[pue_pkg::EV_TWR]);
            mstStop <= dmaDramErr | mAbt | tAbtRx | (dmaErr & isDma);
        end
    end

    assign perrOut = 1'b0;

    always_ff @(posedge clk) begin
        if (rst) begin
            delayedReadValid <= 1'b0;
        end else if (ev & evt_ff[pue_pkg::EV_DTX]) begin
            delayedReadValid <= 1'b0;
        end else if (delayedReadStart) begin
            delayedReadValid <= 1'b1;
        end
    end

    // Direct transfers; writes in PCI reset end here
    always_ff @(posedge clk) begin
        if (rst) begin
            dirIssue <= 1'b0;
            dirRspValid <= 1'b0;
            dirRspData <= 32'h0;
            dirRspErr <= 1'b0;
        end else begin
            dirIssue <= dirReq & ~pciInReset;
            dirRspValid <= (dirReq & pciInReset & ~dirWrite) | coreRdValid;
            dirRspErr <= coreRdValid & coreRdParErr & perrResp;
            if (dirReq & pciInReset & ~dirWrite) begin
                dirRspData <= 32'hffffffff;
            end else if (coreRdValid) begin
                dirRspData <= coreRdData;
            end
        end
    end

    // Lane alignment; longword order is never touched
    always_ff @(posedge clk) begin
        if (rst) begin
            memDataOut <= 64'h0;
            memBenOut <= 8'h00;
            pciDataOut <= 64'h0;
            pciBenOut <= 8'h00;
        end else begin
            memDataOut <= ctrl_ff[pue_pkg::CTL_IN_DATA_BE] ? swapBytes(pciDataIn)
                : pciDataIn;
            pciDataOut <= ctrl_ff[pue_pkg::CTL_OUT_DATA_BE] ? swapBytes(memDataIn)
                : memDataIn;
            // Enables may be swapped without the data; stray bytes are don't-care
            memBenOut <= ctrl_ff[pue_pkg::CTL_IN_BEN_SWAP] ? swapBens(pciBenIn)
                : pciBenIn;
            pciBenOut <= ctrl_ff[pue_pkg::CTL_OUT_BEN_SWAP] ? swapBens(memBenIn)
                : memBenIn;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence sAparEvt;
        evtValid_ff && evt_ff[pue_pkg::EV_TDEC] && evt_ff[pue_pkg::EV_APAR];
    endsequence

    a_par_quiet: assert property ((sAparEvt and !perrResp) |=> !flags_ff[pue_pkg::F_TGT_ADR]
        || $past(flags_ff[pue_pkg::F_TGT_ADR])) else $error("parity flag with response off");
    a_addr_noclaim: assert property ((sAparEvt and perrResp) |=> !tgtClaim
        && flags_ff[pue_pkg::F_TGT_ADR]) else $error("address parity cycle claimed");
    a_dtx_drop: assert property (ev && evt_ff[pue_pkg::EV_DTX] |=> !delayedReadValid
        && flags_ff[pue_pkg::F_DTX]) else $error("discard expiry not handled");
    a_csr_abort: assert property (csrBad && evt_ff[pue_pkg::EV_TRD] |=> tgtAbort
        && flags_ff[pue_pkg::F_CSR_BE]) else $error("bad CSR enables not aborted");
    a_twpar_detected_parity_status: assert property (twPar |=> !perrOeN && tgtDropWrite && detPar_ff)
        else $error("target write parity not answered");
    a_tmem_abort: assert property (tgtDramErr |=> tgtAbort && flags_ff[pue_pkg::F_TGT_DRAM])
        else $error("target memory error not aborted");
    sequence sChanFail;
        !chanEnable_ff && chanError_ff && chanReset;
    endsequence
    a_chan_err: assert property (dmaErr && !descWr |=> sChanFail ##0 $stable(descPtr_ff))
        else $error("channel error handling wrong");
    a_zero_retire: assert property (descLoad && descWordCount == '0 |=> descRetire)
        else $error("zero count descriptor not retired");
    a_rst_ones: assert property (dirReq && !dirWrite && pciInReset |=> dirRspValid
        && dirRspData == 32'hffffffff && !dirIssue) else $error("reset read not all ones");
    a_flag_sticky: assert property (flags_ff[pue_pkg::F_RMA] && !statusWr |=>
        flags_ff[pue_pkg::F_RMA]) else $error("flag lost without clear");
    a_lane_order: assert property (!ctrl_ff[pue_pkg::CTL_OUT_DATA_BE] |=>
        pciDataOut == $past(memDataIn)) else $error("straight lanes altered");

endmodule // pue_error_lane

/* File: pue_pci_agent.sv */
// PCI-side agent model: free-running link clock and one event set per frame
`timescale 1ns/1ps
module pue_pci_agent (
    input wire logic evtGo,
    input wire logic [19:0] evtReq,
    input wire logic prstN,
    output logic pciClk,
    output logic [19:0] pciEvt,
    output logic [7:0] sentCnt
);
    logic busy;
    initial begin
        pciClk = 1'b0;
        busy = 1'b0;
        sentCnt = 8'h00;
        pciEvt = pue_pkg::EVT_IDLE;
        // Odd offset keeps the link clock out of phase with the block clock
        #37;
        forever #100 pciClk = ~pciClk;
    end
    // Change on the falling edge so each set stands across a whole rising edge
    always @(negedge pciClk) begin
        if (busy) begin
            busy <= 1'b0;
            sentCnt <= sentCnt + 8'h01;
            pciEvt <= pue_pkg::EVT_IDLE ^ {4'h0, ~prstN, 15'h0};
        end else begin
            busy <= evtGo;
            pciEvt <= evtGo ? evtReq : pue_pkg::EVT_IDLE ^ {4'h0, ~prstN, 15'h0};
        end
    end
endmodule // pue_pci_agent

/* File: testbench.sv */
// Self-checking bench: register bus, error events, direct transfers, lanes
`timescale 1ns/1ps
module testbench;
    localparam logic [31:0] CTL = {24'h0, pue_pkg::OFS_CONTROL};
    localparam logic [31:0] ST = {24'h0, pue_pkg::OFS_STATUS};
    localparam logic [31:0] CH = {24'h0, pue_pkg::OFS_CHAN_CTRL};
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, evtGo = 1'b0, prstN = 1'b1;
    logic rdChk = 1'b0, smp = 1'b0, lnChk = 1'b0, clrStk = 1'b0, coreRdParErr = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdData = 32'h0, dp, r;
    logic [63:0] pciDataIn = 64'h0, memDataIn = 64'h0, memDataOut, pciDataOut;
    logic [7:0] pciBenIn = 8'h0, memBenIn = 8'h0, memBenOut, pciBenOut, sentCnt;
    logic [19:0] pciEvt, evtReq = 20'h0;
    logic [8:0] intl = 9'h0;
    logic [15:0] wc = 16'h0;
    logic [9:0] stk = 10'h0;
    logic [11:0] x;
    logic [31:0] hrdata, dirRspData;
    logic hreadyout, hresp, tgtClaim, tgtAbort, tgtDropWrite, delayedReadValid, perrOeN, perrOut;
    logic mstStop, descRetire, chanReset, dirIssue, dirRspValid, dirRspErr, coreIrq, pciClk;
    logic [63:0] expQ[$];
    logic [31:0] ofs[7] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h40, 32'h104};
    logic [19:0] tv[9] = '{20'h900, 20'h1200, 20'h2100, 20'h210, 20'h4200, 20'h1, 20'h2,
        20'h4, 20'h8};
    logic [11:0] te[9] = '{12'h10, 12'h10, 12'h0, 12'h8, 12'h0, 12'h2, 12'h2, 12'h30, 12'h20};
    logic [31:0] ts[9] = '{32'h400, 32'h800, 32'h10100, 32'h10200, 32'h1000, 32'h10, 32'h20,
        32'h40, 32'h80};
    int fails = 0, compares = 0, cyc = 0;

    pue_error_lane pue_error_lane_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pciClk(pciClk),
        .pciEvt(pciEvt), .tgtClaim(tgtClaim), .tgtAbort(tgtAbort), .tgtDropWrite(tgtDropWrite),
        .delayedReadValid(delayedReadValid), .perrOut(perrOut), .perrOeN(perrOeN),
        .mstStop(mstStop), .tgtSramErr(intl[0]), .tgtDramErr(intl[1]), .dmaDramErr(intl[2]),
        .dmaSramErr(intl[3]), .delayedReadStart(intl[4]), .descLoad(intl[5]),
        .descWordCount(wc), .descRetire(descRetire), .chanReset(chanReset), .dirReq(intl[6]),
        .dirWrite(intl[7]), .coreRdValid(intl[8]), .coreRdData(rdData),
        .coreRdParErr(coreRdParErr), .dirIssue(dirIssue), .dirRspValid(dirRspValid),
        .dirRspData(dirRspData), .dirRspErr(dirRspErr), .pciDataIn(pciDataIn),
        .pciBenIn(pciBenIn), .memDataIn(memDataIn), .memBenIn(memBenIn),
        .memDataOut(memDataOut), .memBenOut(memBenOut), .pciDataOut(pciDataOut),
        .pciBenOut(pciBenOut), .coreIrq(coreIrq));
    pue_pci_agent pue_pci_agent_inst (.evtGo(evtGo), .evtReq(evtReq), .prstN(prstN),
        .pciClk(pciClk), .pciEvt(pciEvt), .sentCnt(sentCnt));

    always #12.5 clk = ~clk;

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp(input logic [63:0] got);
        logic [63:0] exp;
        exp = expQ.size() ? expQ.pop_front() : {64{1'bx}};
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // Pulses are caught in a sticky vector so a one-cycle output is never missed
    always @(posedge clk) begin
        stk <= clrStk ? 10'h0 : stk | {dirRspErr & dirRspValid, dirRspValid, dirIssue,
            descRetire, chanReset, mstStop, ~perrOeN, tgtDropWrite, tgtAbort, tgtClaim};
        cyc <= cyc + 1;
        if (rdChk && hreadyout)
            cmp({31'h0, hresp, hrdata});
        if (dirRspValid)
            cmp({32'h0, dirRspData});
        if (smp)
            cmp({51'h0, perrOut, coreIrq, delayedReadValid, stk});
        if (lnChk) begin
            cmp(memDataOut);
            cmp(pciDataOut);
            cmp({48'h0, pciBenOut, memBenOut});
        end
        if (cyc == 10000) begin
            fails++;
            complete_run();
        end
    end

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        rdChk <= ~wr;
        if (!wr)
            expQ.push_back({32'h0, d});
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdChk <= 1'b0;
    endtask

    // Status all ones means the flag register is left unchecked and uncleared
    task automatic stim(input logic pci, input logic [19:0] v, input logic [11:0] ev,
        input logic [31:0] es);
        logic [7:0] s0;
        @(posedge clk);
        clrStk <= 1'b1;
        @(posedge clk);
        clrStk <= 1'b0;
        if (pci) begin
            evtReq <= pue_pkg::EVT_IDLE ^ v;
            evtGo <= 1'b1;
            s0 = sentCnt;
            do @(posedge clk); while (sentCnt == s0);
            evtGo <= 1'b0;
        end else begin
            intl <= v[8:0];
            @(posedge clk);
            intl <= 9'h0;
        end
        repeat (10) @(posedge clk);
        expQ.push_back({52'h0, ev});
        smp <= 1'b1;
        @(posedge clk);
        smp <= 1'b0;
        if (es !== 32'hffffffff) begin
            ahb(0, ST, es);
            ahb(1, ST, 32'hffffffff);
        end
    endtask

    function automatic logic [63:0] sw(input logic [63:0] a);
        for (int i = 0; i < 8; i++)
            sw[8 * i +: 8] = a[8 * (i ^ 3) +: 8];
    endfunction

    function automatic logic [7:0] swb(input logic [7:0] a);
        for (int i = 0; i < 8; i++)
            swb[i] = a[i ^ 3];
    endfunction

    initial begin
        void'($urandom(32'h32af));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (ofs[i])
            ahb(0, ofs[i], 32'h0);
        dp = $urandom;
        ahb(1, ofs[4], dp);
        stim(1, 20'h17, 12'h1, 32'h0);
        ahb(1, CTL, 32'h1);
        stim(1, 20'hb, 12'h0, 32'h1);
        stim(1, 20'h15, 12'hd, 32'h10008);
        stim(1, 20'h10069, 12'h3, 32'h4);
        stim(1, 20'hc0029, 12'h1, 32'h0);
        stim(1, 20'hf0069, 12'h1, 32'h0);
        stim(1, 20'h2009, 12'h1, 32'h0);
        ahb(1, ofs[2], 32'h2);
        stim(0, 20'h10, 12'h400, 32'h0);
        stim(1, 20'h80, 12'h800, 32'h2);
        for (int d = 0; d < 2; d++) begin
            for (int i = 0; i < 9; i++) begin
                ahb(1, CH, 32'h3);
                x = te[i] | ((d && i < 4) ? 12'h30 : 12'h0);
                stim(i < 5, tv[i] | ((d && i < 5) ? 20'h400 : 20'h0), x, ts[i]);
                ahb(0, CH, x[5] ? 32'h2 : 32'h1);
            end
        end
        ahb(0, ofs[4], dp);
        stim(0, 20'h20, 12'h40, 32'h0);
        wc <= 16'h1 | 16'($urandom);
        stim(0, 20'h20, 12'h0, 32'h0);
        prstN <= 1'b0;
        repeat (20) @(posedge clk);
        expQ.push_back(64'hffffffff);
        stim(0, 20'h40, 12'h100, 32'h0);
        stim(0, 20'hc0, 12'h0, 32'h0);
        prstN <= 1'b1;
        repeat (20) @(posedge clk);
        stim(0, 20'h40, 12'h80, 32'hffffffff);
        r = $urandom;
        rdData <= r;
        coreRdParErr <= 1'b1;
        expQ.push_back({32'h0, r});
        stim(0, 20'h100, 12'h300, 32'hffffffff);
        for (int m = 0; m < 16; m++) begin
            ahb(1, CTL, {27'h0, m[3:0], 1'b1});
            pciDataIn <= {$urandom, $urandom};
            memDataIn <= {$urandom, $urandom};
            pciBenIn <= 8'($urandom);
            memBenIn <= 8'($urandom);
            repeat (2) @(posedge clk);
            expQ.push_back(m[0] ? sw(pciDataIn) : pciDataIn);
            expQ.push_back(m[1] ? sw(memDataIn) : memDataIn);
            expQ.push_back({48'h0, m[3] ? swb(memBenIn) : memBenIn,
                m[2] ? swb(pciBenIn) : pciBenIn});
            lnChk <= 1'b1;
            @(posedge clk);
            lnChk <= 1'b0;
        end
        repeat (2) @(posedge clk);
        complete_run();
    end
endmodule // testbench
